// *** carrier_sense_cca_lbt.sv ***
/*
 * Carrier sense, clear channel assessment and listen-before-talk engine
 * with an AXI4-Lite register slave.
 * Assumes rssi, packet and strobe inputs come from logic on ref_clk.
 */
// The register addresses and register access over AXI4-Lite are this design's own decisions.
// Notes on behaviour
// - carrier sense follows rssi against threshold
// - sync search gated by carrier sense if set
// - carrier sense changes only on rssi refresh, and clears outside receive
// - pin codes 17/16 give sense and valid
// - sense and valid readable in status register
// - valid within averaging window plus one update
// - gain updates only delay first rssi refresh
// - pins 1/3 code 15 show clear flag
// - pin 2 pulses once per clear decision
// - pin 0 shows refused after decision
// - transmit strobe in receive needs clear channel
// - refused strobe never retried outside listen mode
// - listen mode retries until transmit entered
// - five clear criteria selected by mode field
// - fixed listen of 5 ms, channel free
// - random extension 0 to 7.5 ms, 0.5 ms steps
// - free start and fixed part: no extension
// - busy restarts listen with random extension
// - listen sequence runs until transmit succeeds
// - link quality appended and readable
`timescale 1ns/1ps
`default_nettype none

module carrier_sense_cca_lbt #(
	parameter int FIXED_CYCLES = cs_cca_pkg::FIXED_CYCLES,
	parameter int STEP_CYCLES  = cs_cca_pkg::STEP_CYCLES
) (
	input  wire logic                          ref_clk,
	input  wire logic                          rst_b,
	// AXI4-Lite slave
	input  wire logic [cs_cca_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [cs_cca_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [31:0]                        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	// radio side
	input  wire logic                          radio_in_rx,
	input  wire logic signed [7:0]             rssi_value,
	input  wire logic                          rssi_refresh_pulse,
	input  wire logic                          packet_receiving,
	input  wire logic                          transmit_strobe,
	input  wire logic                          synth_tx_on_strobe,
	input  wire logic [6:0]                    link_quality_value,
	input  wire logic                          link_crc_ok,
	input  wire logic                          link_quality_load,
	output logic                               carrier_sense,
	output logic                               carrier_sense_valid,
	output logic                               sync_search_enable,
	output logic                               channel_clear_flag,
	output logic                               clear_check_decided,
	output logic                               clear_check_refused,
	output logic                               enter_tx_pulse,
	output logic                               enter_synth_tx_on_pulse,
	output logic [3:0]                         pin_out,
	output logic                               append_status_enable,
	output logic [7:0]                         appended_status_byte
);

	localparam int TIMER_W = cs_cca_pkg::TIMER_W; // unscoped alias for widths and casts

	cs_cca_pkg::state_t s_q;
	cs_cca_pkg::state_t s_d;

	logic signed [7:0] thr;
	logic [2:0]        mode;
	logic              gate;
	logic [1:0]        avg;
	logic [3:0]        need;
	logic              strobe;
	logic              busy;
	logic              basic_clear;

	////////////////////////////////////////////////////////////////////////
	// config field extraction
	assign thr    = s_q.cfg[cs_cca_pkg::CFG_THR_LSB +: 8];
	assign mode   = s_q.cfg[cs_cca_pkg::CFG_MODE_LSB +: 3];
	assign gate   = s_q.cfg[cs_cca_pkg::CFG_GATE_BIT];
	assign avg    = s_q.cfg[cs_cca_pkg::CFG_AVG_LSB +: 2];
	// average window is 2^n new samples plus one
	assign need   = 4'((4'h1 << avg) + 4'h1);
	assign strobe = transmit_strobe | synth_tx_on_strobe;
	assign busy   = s_q.cs;

	// criteria other than listen timing, evaluated on the current sense
	always_comb begin
		unique case (mode)
			cs_cca_pkg::MODE_RSSI:  basic_clear = !s_q.cs;
			cs_cca_pkg::MODE_NOPKT: basic_clear = !packet_receiving;
			cs_cca_pkg::MODE_BOTH:  basic_clear = !s_q.cs && !packet_receiving;
			cs_cca_pkg::MODE_LBT:   basic_clear = !s_q.cs;
			default:                basic_clear = 1'b1; // reserved codes act as always
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		logic [5:0]  sel;
		logic [31:0] merged;
		logic        finish;
		sel    = '0;
		merged = '0;
		finish = 1'b0;
		s_d    = s_q;

		// one-cycle pulses fall back every cycle
		s_d.decided    = 1'b0;
		s_d.enter_tx   = 1'b0;
		s_d.enter_fstx = 1'b0;
		// free-running source for the random extension
		s_d.lfsr = {s_q.lfsr[6:0], s_q.lfsr[7] ^ s_q.lfsr[5] ^ s_q.lfsr[4] ^ s_q.lfsr[3]};

		// sense moves only on an rssi refresh; outside receive it is cleared
		if (!radio_in_rx) begin
			s_d.cs       = 1'b0;
			s_d.cs_valid = 1'b0;
			s_d.upd_cnt  = '0;
		end else if (rssi_refresh_pulse) begin
			// equal to threshold keeps the previous sense
			if (rssi_value > thr)
				s_d.cs = 1'b1;
			else if (rssi_value < thr)
				s_d.cs = 1'b0;
			// counts refreshes only, so gain settles merely delay it
			if (s_q.upd_cnt != need)
				s_d.upd_cnt = s_q.upd_cnt + 4'h1;
			if (s_q.upd_cnt + 4'h1 >= need)
				s_d.cs_valid = 1'b1;
		end

		// immediate decision outside listen mode
		if (strobe && radio_in_rx && mode != cs_cca_pkg::MODE_LBT) begin
			s_d.decided = 1'b1;
			s_d.refused = !basic_clear;
			// refused strobe is dropped, no later retry
			s_d.enter_tx   = basic_clear && transmit_strobe;
			s_d.enter_fstx = basic_clear && !transmit_strobe;
		end

		// listen-before-talk sequencer
		if (!radio_in_rx || mode != cs_cca_pkg::MODE_LBT) begin
			s_d.lbt = cs_cca_pkg::LBT_IDLE;
		end else begin
			unique case (s_q.lbt)
				cs_cca_pkg::LBT_IDLE: begin
					if (strobe) begin
						s_d.tgt_synth   = !transmit_strobe;
						s_d.timer       = '0;
						s_d.backoff_req = busy;
						s_d.lbt         = busy ? cs_cca_pkg::LBT_BUSY : cs_cca_pkg::LBT_LISTEN;
					end
				end
				cs_cca_pkg::LBT_BUSY: begin
					// listen restarts from the instant the channel frees
					if (!busy) begin
						s_d.timer       = '0;
						s_d.backoff_req = 1'b1;
						s_d.lbt         = cs_cca_pkg::LBT_LISTEN;
					end
				end
				cs_cca_pkg::LBT_LISTEN: begin
					if (busy) begin
						s_d.lbt = cs_cca_pkg::LBT_BUSY;
					end else if (s_q.timer == TIMER_W'(FIXED_CYCLES - 1)) begin
						s_d.timer = '0;
						if (s_q.backoff_req && s_q.lfsr[3:0] != 4'h0) begin
							s_d.steps = s_q.lfsr[3:0];
							s_d.lbt   = cs_cca_pkg::LBT_BACKOFF;
						end else begin
							finish = 1'b1;
						end
					end else begin
						s_d.timer = s_q.timer + 1'b1;
					end
				end
				cs_cca_pkg::LBT_BACKOFF: begin
					if (busy) begin
						s_d.lbt = cs_cca_pkg::LBT_BUSY;
					end else if (s_q.timer == TIMER_W'(STEP_CYCLES - 1)) begin
						s_d.timer = '0;
						s_d.steps = s_q.steps - 4'h1;
						finish    = (s_q.steps == 4'h1);
					end else begin
						s_d.timer = s_q.timer + 1'b1;
					end
				end
			endcase
			// keeps going until the transmit is actually entered
			if (finish) begin
				s_d.lbt        = cs_cca_pkg::LBT_IDLE;
				s_d.decided    = 1'b1;
				s_d.refused    = 1'b0;
				s_d.enter_tx   = !s_q.tgt_synth;
				s_d.enter_fstx = s_q.tgt_synth;
			end
		end

		// clear flag; in listen mode the timing must also have been met
		if (mode == cs_cca_pkg::MODE_LBT)
			s_d.clear = basic_clear && finish;
		else
			s_d.clear = basic_clear;

		// pin multiplexer, registered so pins never glitch
		for (int p = 0; p < 4; p++) begin
			sel = s_q.sel[p*cs_cca_pkg::PINSEL_STRIDE +: 6];
			if (sel == cs_cca_pkg::SEL_CS)
				s_d.pins[p] = s_q.cs;
			else if (sel == cs_cca_pkg::SEL_CS_VALID)
				s_d.pins[p] = s_q.cs_valid;
			else if (sel == cs_cca_pkg::SEL_CCA && (p == 1 || p == 3))
				s_d.pins[p] = s_q.clear;
			else if (sel == cs_cca_pkg::SEL_CCA && p == 2)
				s_d.pins[p] = s_q.decided;
			else if (sel == cs_cca_pkg::SEL_CCA && p == 0)
				s_d.pins[p] = s_q.refused;
			else
				s_d.pins[p] = 1'b0;
		end

		// link quality capture with crc flag in the top bit
		if (link_quality_load)
			s_d.lqi = {link_crc_ok, link_quality_value};

		// write channels, taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			s_d.aw_have = 1'b1;
			s_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_d.w_have = 1'b1;
			s_d.wdata  = s_axi_wdata;
			s_d.wstrb  = s_axi_wstrb;
		end
		if (s_q.aw_have && s_q.w_have) begin
			s_d.aw_have = 1'b0;
			s_d.w_have  = 1'b0;
			s_d.bvalid  = 1'b1;
			s_d.bresp   = cs_cca_pkg::RESP_OKAY;
			for (int b = 0; b < 4; b++)
				merged[8*b +: 8] = s_q.wstrb[b] ? s_q.wdata[8*b +: 8] : 8'h00;
			unique case (s_q.aw_addr)
				cs_cca_pkg::ADDR_CONFIG:
					for (int b = 0; b < 4; b++)
						if (s_q.wstrb[b])
							s_d.cfg[8*b +: 8] = merged[8*b +: 8] & cs_cca_pkg::CFG_MASK[8*b +: 8];
				cs_cca_pkg::ADDR_PINSEL:
					for (int b = 0; b < 4; b++)
						if (s_q.wstrb[b])
							s_d.sel[8*b +: 8] = merged[8*b +: 8] & cs_cca_pkg::PINSEL_MASK[8*b +: 8];
				// status and link quality are read-only
				cs_cca_pkg::ADDR_STATUS, cs_cca_pkg::ADDR_LQI: ;
				default: s_d.bresp = cs_cca_pkg::RESP_SLVERR;
			endcase
		end
		if (s_q.bvalid && s_axi_bready)
			s_d.bvalid = 1'b0;

		// read channel, answer the cycle after the address is taken
		if (s_axi_arvalid && s_axi_arready) begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = cs_cca_pkg::RESP_OKAY;
			unique case (s_axi_araddr)
				cs_cca_pkg::ADDR_CONFIG: s_d.rdata = s_q.cfg;
				cs_cca_pkg::ADDR_PINSEL: s_d.rdata = s_q.sel;
				cs_cca_pkg::ADDR_STATUS:
					s_d.rdata = {24'h00_0000, s_q.lbt, 2'h0, s_q.refused, s_q.clear,
						s_q.cs, s_q.cs_valid};
				cs_cca_pkg::ADDR_LQI:    s_d.rdata = {24'h00_0000, s_q.lqi};
				default: begin
					s_d.rdata = 32'h0000_0000;
					s_d.rresp = cs_cca_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q      <= '0;
			s_q.cfg  <= cs_cca_pkg::CFG_RESET;
			s_q.sel  <= cs_cca_pkg::PINSEL_RESET;
			s_q.lfsr <= cs_cca_pkg::LFSR_SEED;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	// one write and one read in flight; hold channels while answering
	assign s_axi_awready = !s_q.aw_have && !s_q.bvalid;
	assign s_axi_wready  = !s_q.w_have && !s_q.bvalid;
	assign s_axi_bvalid  = s_q.bvalid;
	assign s_axi_bresp   = s_q.bresp;
	assign s_axi_arready = !s_q.rvalid;
	assign s_axi_rvalid  = s_q.rvalid;
	assign s_axi_rdata   = s_q.rdata;
	assign s_axi_rresp   = s_q.rresp;

	assign carrier_sense           = s_q.cs;
	assign carrier_sense_valid     = s_q.cs_valid;
	assign sync_search_enable      = !gate || s_q.cs;
	assign channel_clear_flag      = s_q.clear;
	assign clear_check_decided     = s_q.decided;
	assign clear_check_refused     = s_q.refused;
	assign enter_tx_pulse          = s_q.enter_tx;
	assign enter_synth_tx_on_pulse = s_q.enter_fstx;
	assign pin_out                 = s_q.pins;
	assign append_status_enable    = s_q.cfg[cs_cca_pkg::CFG_APPEND_BIT];
	assign appended_status_byte    = s_q.lqi;

	////////////////////////////////////////////////////////////////////////
	// checks: free-running count of consecutive idle-channel cycles
	logic [TIMER_W-1:0] free_run_q;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			free_run_q <= '0;
		else if (s_q.cs)
			free_run_q <= '0;
		else if (free_run_q != '1)
			free_run_q <= free_run_q + 1'b1;
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	a_cs_above_thr: assert property (
		radio_in_rx && rssi_refresh_pulse && rssi_value > thr |=> carrier_sense)
		else $error("sense not raised above threshold");
	a_cs_below_thr: assert property (
		radio_in_rx && rssi_refresh_pulse && rssi_value < thr |=> !carrier_sense)
		else $error("sense not dropped below threshold");
	a_cs_only_refresh: assert property (
		radio_in_rx && !rssi_refresh_pulse |=> $stable(carrier_sense))
		else $error("sense moved without rssi refresh");
	a_sync_gate_off: assert property (
		gate && !carrier_sense |-> !sync_search_enable)
		else $error("sync search open without sense");
	a_valid_window: assert property (
		radio_in_rx && rssi_refresh_pulse && s_q.upd_cnt == need - 4'h1
		|=> carrier_sense_valid)
		else $error("sense valid late");
	a_pin_cs_route: assert property (
		s_q.sel[5:0] == cs_cca_pkg::SEL_CS |=> pin_out[0] == $past(carrier_sense))
		else $error("pin 0 does not show sense");
	a_refuse_stay: assert property (
		strobe && radio_in_rx && mode != cs_cca_pkg::MODE_LBT && !basic_clear
		|=> !enter_tx_pulse && !enter_synth_tx_on_pulse && clear_check_refused)
		else $error("busy channel let transmit through");
	a_no_auto_tx: assert property (
		!strobe && mode != cs_cca_pkg::MODE_LBT |=> !enter_tx_pulse)
		else $error("transmit entered without strobe");
	a_lbt_fixed_free: assert property (
		enter_tx_pulse && $past(mode) == cs_cca_pkg::MODE_LBT
		|-> free_run_q >= TIMER_W'(FIXED_CYCLES))
		else $error("transmit before fixed listen time");
	a_decided_pulse: assert property (
		clear_check_decided |=> !clear_check_decided ##1 1'b1)
		else $error("decision pulse longer than one cycle");
	a_always_clear: assert property (
		mode == cs_cca_pkg::MODE_ALWAYS |=> channel_clear_flag)
		else $error("always mode not clear");

	c_lbt_enter: cover property (
		mode == cs_cca_pkg::MODE_LBT && s_q.lbt == cs_cca_pkg::LBT_BACKOFF ##1 enter_tx_pulse);
	c_refused: cover property (clear_check_decided && clear_check_refused);
	c_cs_valid: cover property (!carrier_sense_valid ##1 carrier_sense_valid && carrier_sense);

endmodule : carrier_sense_cca_lbt

`default_nettype wire

// *** cs_cca_pkg.sv ***
/*
 * Shared constants and state types for the carrier sense / clear channel
 * assessment / listen-before-talk block.
 * Assumes a single 20 MHz clock and an AXI4-Lite register port.
 */
package cs_cca_pkg;

	// clock and timing, times in their own units
	localparam int CLK_HZ          = 20000000;
	localparam int LISTEN_FIXED_US = 5000;
	localparam int LISTEN_STEP_US  = 500;
	localparam int FIXED_CYCLES    = (LISTEN_FIXED_US * (CLK_HZ / 1000000));
	localparam int STEP_CYCLES     = (LISTEN_STEP_US * (CLK_HZ / 1000000));
	localparam int TIMER_W         = 20;

	// register bus
	localparam int          ADDR_W      = 8;
	localparam logic [7:0]  ADDR_CONFIG = 8'h00;
	localparam logic [7:0]  ADDR_PINSEL = 8'h04;
	localparam logic [7:0]  ADDR_STATUS = 8'h08;
	localparam logic [7:0]  ADDR_LQI    = 8'h0c;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// config register layout
	localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
	localparam logic [31:0] CFG_MASK    = 32'h0000_7fff;
	localparam int          CFG_THR_LSB = 0;
	localparam int          CFG_MODE_LSB = 8;
	localparam int          CFG_GATE_BIT = 11;
	localparam int          CFG_AVG_LSB = 12;
	localparam int          CFG_APPEND_BIT = 14;

	// pin select register: one 6-bit code per pin, one byte per pin
	localparam logic [31:0] PINSEL_RESET = 32'h0000_0000;
	localparam logic [31:0] PINSEL_MASK  = 32'h3f3f_3f3f;
	localparam int          PINSEL_STRIDE = 8;
	localparam logic [5:0]  SEL_CS       = 6'h11;
	localparam logic [5:0]  SEL_CS_VALID = 6'h10;
	localparam logic [5:0]  SEL_CCA      = 6'h0f;

	// clear check modes
	localparam logic [2:0] MODE_ALWAYS  = 3'h0;
	localparam logic [2:0] MODE_RSSI    = 3'h1;
	localparam logic [2:0] MODE_NOPKT   = 3'h2;
	localparam logic [2:0] MODE_BOTH    = 3'h3;
	localparam logic [2:0] MODE_LBT     = 3'h4;

	localparam logic [7:0] LFSR_SEED = 8'h01;

	typedef enum logic [1:0] {
		LBT_IDLE    = 2'b00,
		LBT_BUSY    = 2'b01,
		LBT_LISTEN  = 2'b10,
		LBT_BACKOFF = 2'b11
	} lbt_state_t;

	typedef struct packed {
		logic [31:0]        cfg;
		logic [31:0]        sel;
		logic               cs;
		logic               cs_valid;
		logic [3:0]         upd_cnt;
		logic               clear;
		logic               decided;
		logic               refused;
		logic               enter_tx;
		logic               enter_fstx;
		lbt_state_t         lbt;
		logic [TIMER_W-1:0] timer;
		logic [3:0]         steps;
		logic               backoff_req;
		logic               tgt_synth;
		logic [7:0]         lfsr;
		logic [3:0]         pins;
		logic [7:0]         lqi;
		logic               aw_have;
		logic [ADDR_W-1:0]  aw_addr;
		logic               w_have;
		logic [31:0]        wdata;
		logic [3:0]         wstrb;
		logic               bvalid;
		logic [1:0]         bresp;
		logic               rvalid;
		logic [31:0]        rdata;
		logic [1:0]         rresp;
	} state_t;

endpackage : cs_cca_pkg

// *** rssi_source.sv ***
/*
 * Radio front end model: periodic rssi estimates with a refresh pulse.
 * Assumes the bench picks the level to report; shares ref_clk with the block.
 */
`timescale 1ns/1ps
`default_nettype none

module rssi_source #(
	parameter int PERIOD = 8
) (
	input  wire logic              ref_clk,
	input  wire logic              rst_b,
	input  wire logic signed [7:0] level,
	output logic signed [7:0]      rssi_value,
	output logic                   rssi_refresh_pulse
);
	int cnt_q;

	// estimate holds only in the pulse cycle; junk otherwise so no stale value passes
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= 0;
			rssi_refresh_pulse <= 1'b0;
			rssi_value <= 8'sh00;
		end else begin
			cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
			rssi_refresh_pulse <= (cnt_q == PERIOD - 1);
			rssi_value <= (cnt_q == PERIOD - 1) ? level : ~level;
		end
	end
endmodule : rssi_source

`default_nettype wire

// *** tb.sv ***
/*
 * Self-checking bench: AXI4-Lite master, radio stimulus, scenario tasks.
 * Assumes the block on ref_clk at 20 MHz with shortened listen counts.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
	localparam int FIX = 20;
	localparam int STEP = 4;
	localparam int PER = 8;
	// {mode, rssi high, packet, clear expected}
	// last entry is a reserved mode code, which must act as always clear
	localparam logic [5:0] TBL [9] = '{6'h07, 6'h0c, 6'h16, 6'h15, 6'h1a, 6'h1c, 6'h19,
		6'h0b, 6'h2f};
	logic              ref_clk, rst_b;
	logic [7:0]        awaddr, araddr, app_byte;
	logic [31:0]       wdata, rdata, rd;
	logic [3:0]        wstrb, pins;
	logic              awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready;
	logic [1:0]        bresp, rresp, resp;
	logic              in_rx, pkt, tx_stb, fs_stb, lq_load, lq_crc, refresh;
	logic [6:0]        lq_val;
	logic signed [7:0] level, rssi;
	logic              cs, cs_ok, sync_en, clear, decided, refused, ent_tx, ent_fs, app_en;
	logic              en, rf;
	int                miscompares = 0, n_checks = 0, n_enter = 0, at;

	carrier_sense_cca_lbt #(.FIXED_CYCLES(FIX), .STEP_CYCLES(STEP)) DUT (
		.ref_clk(ref_clk), .rst_b(rst_b),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .radio_in_rx(in_rx),
		.rssi_value(rssi), .rssi_refresh_pulse(refresh), .packet_receiving(pkt),
		.transmit_strobe(tx_stb), .synth_tx_on_strobe(fs_stb),
		.link_quality_value(lq_val), .link_crc_ok(lq_crc), .link_quality_load(lq_load),
		.carrier_sense(cs), .carrier_sense_valid(cs_ok), .sync_search_enable(sync_en),
		.channel_clear_flag(clear), .clear_check_decided(decided),
		.clear_check_refused(refused), .enter_tx_pulse(ent_tx),
		.enter_synth_tx_on_pulse(ent_fs), .pin_out(pins),
		.append_status_enable(app_en), .appended_status_byte(app_byte)
	);

	rssi_source #(.PERIOD(PER)) src (
		.ref_clk(ref_clk), .rst_b(rst_b), .level(level),
		.rssi_value(rssi), .rssi_refresh_pulse(refresh)
	);

	////////////////////////////////////////
	// clock, and a count of transmit entries for the no-retry check
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (ent_tx === 1'b1) n_enter <= n_enter + 1;
	end

	////////////////////////////////////////
	// reporting
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task stop_test;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : stop_test

	task tmo(input string nm);
		miscompares++;
		$display("MISMATCH %s expected answer seen timeout", nm);
		stop_test();
	endtask : tmo

	////////////////////////////////////////
	// bus master: handshakes judged at the negedge, acted on at the next posedge
	task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ag, wg, bg;
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 40; n++) begin
			@(negedge ref_clk);
			ag = awvalid & awready;
			wg = wvalid & wready;
			bg = bvalid & bready;
			r = bresp;
			@(posedge ref_clk);
			if (ag) awvalid <= 1'b0;
			if (wg) wvalid <= 1'b0;
			if (bg) begin
				bready <= 1'b0;
				return;
			end
		end
		tmo("write");
	endtask : axi_wr

	task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ag, rg;
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 40; n++) begin
			@(negedge ref_clk);
			ag = arvalid & arready;
			rg = rvalid & rready;
			d = rdata;
			r = rresp;
			@(posedge ref_clk);
			if (ag) arvalid <= 1'b0;
			if (rg) begin
				rready <= 1'b0;
				return;
			end
		end
		tmo("read");
	endtask : axi_rd

	function automatic logic [31:0] cfg(input logic [2:0] m, input logic g, input logic ap);
		return {17'h00000, ap, 2'h1, g, m, 8'hba};
	endfunction : cfg

	// wait out three model refresh periods so sense has caught up
	task set_rssi(input logic hi);
		@(posedge ref_clk);
		level <= hi ? 8'shd8 : 8'sh9c;
		repeat (3 * PER) @(posedge ref_clk);
	endtask : set_rssi

	task strobe(input int lim, input logic fs, output int t, output logic e, output logic f);
		@(posedge ref_clk);
		if (fs) fs_stb <= 1'b1;
		else tx_stb <= 1'b1;
		@(posedge ref_clk);
		fs_stb <= 1'b0;
		tx_stb <= 1'b0;
		t = -1;
		for (int n = 0; n < lim && t < 0; n++) begin
			@(negedge ref_clk);
			if (decided === 1'b1) begin
				t = n;
				e = fs ? ent_fs : ent_tx;
			end
		end
		if (t < 0) tmo("decision");
		@(negedge ref_clk);
		f = refused;
	endtask : strobe

	////////////////////////////////////////
	// scenarios
	task t_reset;
		chk("sync_en", 1, sync_en);
		axi_rd(8'h00, rd, resp);
		chk("config", cs_cca_pkg::CFG_RESET, rd);
		axi_rd(8'h04, rd, resp);
		chk("pinsel", cs_cca_pkg::PINSEL_RESET, rd);
		axi_rd(8'h10, rd, resp);
		chk("rresp", cs_cca_pkg::RESP_SLVERR, resp);
		axi_wr(8'h10, 32'h0000_00ff, resp);
		chk("bresp", cs_cca_pkg::RESP_SLVERR, resp);
	endtask : t_reset

	task t_sense;
		axi_wr(8'h00, cfg(3'h1, 1'b0, 1'b0), resp);
		axi_wr(8'h04, 32'h0f0f_1011, resp);
		set_rssi(1'b1);
		chk("cs", 1, cs);
		chk("pin cs", 1, pins[0]);
		axi_rd(8'h08, rd, resp);
		chk("status", 2'h3, rd[1:0]);
		set_rssi(1'b0);
		chk("cs", 0, cs);
		chk("pin valid", 1, pins[1]);
		axi_rd(8'h08, rd, resp);
		chk("status", 2'h1, rd[1:0]);
	endtask : t_sense

	// averaging count 1: valid follows the third refresh in receive
	task t_valid;
		int k;
		@(posedge ref_clk);
		in_rx <= 1'b0;
		@(posedge ref_clk);
		in_rx <= 1'b1;
		k = 0;
		for (int n = 0; n < 100 && k < 3; n++) begin
			@(negedge ref_clk);
			if (refresh === 1'b1) k++;
		end
		chk("valid early", 0, cs_ok);
		@(negedge ref_clk);
		chk("valid", 1, cs_ok);
	endtask : t_valid

	task t_gate;
		axi_wr(8'h00, cfg(3'h1, 1'b1, 1'b0), resp);
		chk("sync_en", 0, sync_en);
		set_rssi(1'b1);
		chk("sync_en", 1, sync_en);
	endtask : t_gate

	task t_modes;
		int e;
		logic [5:0] v;
		axi_wr(8'h04, 32'h110f_0f0f, resp);
		for (int i = 0; i < 9; i++) begin
			v = TBL[i];
			axi_wr(8'h00, cfg(v[5:3], 1'b0, 1'b0), resp);
			pkt <= v[1];
			set_rssi(v[2]);
			chk("pin clear", v[0], pins[1]);
			chk("clear", v[0], clear);
			chk("pin cs", v[2], pins[3]);
			strobe(10, i[0], at, en, rf);
			chk("latency", 0, at);
			chk("enter", v[0], en);
			chk("refused", !v[0], rf);
			chk("pin decided", 1, pins[2]);
			@(negedge ref_clk);
			chk("pin decided", 0, pins[2]);
			chk("pin refused", !v[0], pins[0]);
		end
		axi_wr(8'h00, cfg(3'h1, 1'b0, 1'b0), resp);
		set_rssi(1'b1);
		e = n_enter;
		strobe(10, 1'b0, at, en, rf);
		set_rssi(1'b0);
		chk("no retry", e, n_enter);
	endtask : t_modes

	task t_lbt;
		pkt <= 1'b0;
		axi_wr(8'h00, cfg(3'h4, 1'b0, 1'b0), resp);
		set_rssi(1'b0);
		strobe(FIX + 10, 1'b0, at, en, rf);
		chk("lbt enter", 1, en);
		chk("fixed only", 1, at >= FIX - 2 && at <= FIX + 2);
		set_rssi(1'b1);
		fork
			strobe(400, 1'b0, at, en, rf);
			begin
				repeat (30) @(posedge ref_clk);
				level <= 8'sh9c;
			end
		join
		chk("lbt enter", 1, en);
		chk("lbt refused", 0, rf);
		chk("backoff", 1, at > 28 + FIX && at <= 36 + PER + FIX + 15 * STEP);
	endtask : t_lbt

	task t_lqi;
		axi_wr(8'h00, cfg(3'h0, 1'b0, 1'b1), resp);
		chk("append", 1, app_en);
		@(posedge ref_clk);
		lq_val <= 7'h55;
		lq_crc <= 1'b1;
		lq_load <= 1'b1;
		@(posedge ref_clk);
		lq_load <= 1'b0;
		axi_wr(8'h0c, 32'h0, resp);
		chk("bresp ro", cs_cca_pkg::RESP_OKAY, resp);
		axi_rd(8'h0c, rd, resp);
		chk("lqi reg", 32'h0000_00d5, rd);
		chk("lqi byte", 8'hd5, app_byte);
	endtask : t_lqi

	////////////////////////////////////////
	// main sequence and watchdog
	initial begin
		{awaddr, araddr, wdata, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{pkt, tx_stb, fs_stb, lq_load, lq_crc, lq_val} = '0;
		in_rx = 1'b1;
		level = 8'sh9c;
		rst_b = 1'b0;
		repeat (16) @(posedge ref_clk);
		rst_b <= 1'b1;
		t_reset();
		t_sense();
		t_valid();
		t_gate();
		t_modes();
		t_lbt();
		t_lqi();
		stop_test();
	end
	initial begin
		repeat (60000) @(posedge ref_clk);
		tmo("run");
	end
endmodule : tb

`default_nettype wire
